// File: include/uart_ctl_pkg.sv
// Constants, field layout and select type of the serial control block
package uart_ctl_pkg;
    // Clock cycles per serial bit; the divider value is a plain default
    localparam int BIT_CYCLES = 16;
    localparam int BAUD_W = 5;
    localparam logic [4:0] BIT_LAST = 5'(BIT_CYCLES - 1);
    localparam logic [4:0] SAMP_LO = 5'(BIT_CYCLES / 2 - 1);
    localparam logic [4:0] SAMP_HI = 5'(BIT_CYCLES / 2 + 1);
    localparam logic [3:0] FRAME8 = 4'ha;
    localparam logic [3:0] FRAME9 = 4'hb;
    localparam logic [3:0] STOP8 = 4'h9;
    localparam logic [3:0] STOP9 = 4'ha;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_LINE = 6'h13;
    localparam logic [5:0] IDX_TXRX = 6'h14;
    localparam logic [5:0] IDX_NINTH = 6'h15;
    localparam logic [5:0] IDX_STAT = 6'h16;
    localparam logic [5:0] IDX_DATA = 6'h18;
    localparam logic [7:0] LINE_RST = 8'h00;
    localparam logic [7:0] TXRX_RST = 8'h00;
    localparam logic [5:0] NINTH_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int LF_LOOP = 7, LF_ENA = 6, LF_NINE = 4, LF_WAKE = 3;
    localparam int LF_IDLEPOS = 2, LF_PAREN = 1, LF_PARODD = 0;
    localparam int TR_EMPIE = 7, TR_DONEIE = 6, TR_FULLIE = 5, TR_IDLEIE = 4;
    localparam int TR_TXEN = 3, TR_RXEN = 2, TR_STBY = 1, TR_BRK = 0;
    localparam int NB_DMARX = 5, NB_DMATX = 4, NB_OVIE = 3, NB_NOIE = 2;
    localparam int NB_FRIE = 1, NB_PARIE = 0;
    typedef struct packed {
        logic line;
        logic txrx;
        logic ninth;
        logic stat;
        logic data;
    } regSel_s;
endpackage

// File: include/tx_link_if.sv
// Link between the register block and its transmit shifter
interface tx_link_if;
    logic modEnable;
    logic txEnable;
    logic sendBreak;
    logic nineBit;
    logic parityEn;
    logic parityOdd;
    logic loadValid;
    logic [7:0] loadData;
    logic loadNinth;
    logic loadTaken;
    logic active;
    logic txd;
    modport ctrl (output modEnable, txEnable, sendBreak, nineBit, parityEn, parityOdd,
        loadValid, loadData, loadNinth, input loadTaken, active, txd);
    modport engine (input modEnable, txEnable, sendBreak, nineBit, parityEn, parityOdd,
        loadValid, loadData, loadNinth, output loadTaken, active, txd);
endinterface

// File: src/uart_tx_engine.sv
// Transmit shifter: preamble, break and data characters onto the line
module uart_tx_engine (
    input wire logic clk,
    input wire logic nrst,
    tx_link_if.engine lnk
);
    logic [uart_ctl_pkg::BAUD_W-1:0] baud_ff;
    logic [10:0] sh_ff;
    logic [3:0] left_ff;
    logic pend_ff;
    logic teDly_ff;
    logic tail_ff;

    wire tick = baud_ff == uart_ctl_pkg::BIT_LAST;
    // New work only starts at the last bit of a character or when idle, so it always finishes
    wire slot = tick && left_ff <= 4'h1;
    wire [3:0] frameLen = lnk.nineBit ? uart_ctl_pkg::FRAME9 : uart_ctl_pkg::FRAME8;
    wire brkOn = lnk.txEnable & lnk.sendBreak;
    wire selBrk = slot & brkOn;
    // Break wins over a pending preamble
    wire selPre = slot & lnk.txEnable & pend_ff & !lnk.sendBreak;
    wire selTail = slot & tail_ff & !brkOn;
    wire selData = slot & lnk.txEnable & lnk.loadValid & !lnk.sendBreak & !pend_ff & !tail_ff;
    wire parBit = ^{lnk.nineBit & lnk.loadData[7], lnk.loadData[6:0]} ^ lnk.parityOdd;
    wire bit7 = (lnk.parityEn & !lnk.nineBit) ? parBit : lnk.loadData[7];
    wire bit8 = !lnk.nineBit | (lnk.parityEn ? parBit : lnk.loadNinth);
    wire [10:0] frame = {1'b1, bit8, bit7, lnk.loadData[6:0], 1'b0};
    wire [10:0] nxt_sh = selBrk ? 11'h000 : (selPre | selTail) ? 11'h7ff :
        selData ? frame : tick ? {1'b1, sh_ff[10:1]} : sh_ff;
    wire [3:0] nxt_left = (selBrk | selPre | selData) ? frameLen : selTail ? 4'h1 :
        (tick && left_ff != 4'h0) ? left_ff - 4'h1 : left_ff;
    wire pendSet = lnk.txEnable & !teDly_ff;

    assign lnk.loadTaken = selData;
    assign lnk.txd = (left_ff != 4'h0) ? sh_ff[0] : 1'b1;
    assign lnk.active = (left_ff != 4'h0) | (pend_ff & lnk.txEnable) | tail_ff | brkOn;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            baud_ff <= '0;
            sh_ff <= '1;
            left_ff <= 4'h0;
            pend_ff <= 1'b0;
            teDly_ff <= 1'b0;
            tail_ff <= 1'b0;
        end else if (!lnk.modEnable) begin
            baud_ff <= '0;
            sh_ff <= '1;
            left_ff <= 4'h0;
            pend_ff <= 1'b0;
            teDly_ff <= 1'b0;
            tail_ff <= 1'b0;
        end else begin
            baud_ff <= tick ? '0 : baud_ff + 1'b1;
            sh_ff <= nxt_sh;
            left_ff <= nxt_left;
            pend_ff <= pendSet | (pend_ff & !(selPre | selBrk));
            teDly_ff <= lnk.txEnable;
            tail_ff <= selBrk | (tail_ff & !selTail);
        end
    end

    brk_line_low_a: assert property (@(posedge clk) disable iff (!nrst)
        selBrk |=> (!lnk.txd) [*8])
        else $error("break character did not hold the line low");
    pre_line_high_a: assert property (@(posedge clk) disable iff (!nrst)
        selPre |=> lnk.txd [*8])
        else $error("preamble did not hold the line high");
    brk_seen_c: cover property (@(posedge clk) disable iff (!nrst) selBrk ##[1:400] selTail);
endmodule

// File: src/uart_control_registers.sv
// Control register block of the serial transceiver with AXI4-Lite access
// Functional notes
// - Loopback disconnects the receive pin and feeds transmitter output to receiver.
// - Module enable runs the block; clearing it sets empty and done flags.
// - Character length select picks 10-bit or 11-bit characters.
// - Wake select chooses address-mark or idle-line wakeup; cleared by reset.
// - Idle count starts after stop bit when set, after start bit otherwise.
// - Parity enable puts parity in the character's most significant bit.
// - Parity odd select picks odd or even parity generation and check.
// - Four enables gate empty, done, full and idle flags onto interrupts.
// - Setting transmit enable sends a preamble of 10 or 11 ones.
// - Clearing transmit enable finishes the current character, then idles high.
// - Transmit enable cleared and set mid-character queues one idle character.
// - Receive enable runs the receiver; clearing it keeps receiver flags.
// - Standby masks receiver interrupts; selected wake condition clears it.
// - Break bit sends breaks back to back, then one logic 1.
// - Received ninth bit is captured with data; mirrors bit 7 in 8-bit mode.
// - Transmit ninth bit loads into the shifter together with the data.
// - Overrun, noise and framing enables gate their flags onto error interrupt.
// - The transmit/receive enable register reads zero after reset.
// - Address mark clears standby and sets the receiver-full flag.
// - Parity error enable gates the parity flag onto error interrupt.
module uart_control_registers (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic rxd,
    output logic txd,
    output logic txdOe,
    output logic txIrq,
    output logic rxIrq,
    output logic errIrq
);
    typedef enum logic {RX_IDLE, RX_BITS} rxState_e;

    function automatic uart_ctl_pkg::regSel_s decodeIdx(input logic [7:0] a);
        uart_ctl_pkg::regSel_s s;
        s.line = a[7:2] == uart_ctl_pkg::IDX_LINE;
        s.txrx = a[7:2] == uart_ctl_pkg::IDX_TXRX;
        s.ninth = a[7:2] == uart_ctl_pkg::IDX_NINTH;
        s.stat = a[7:2] == uart_ctl_pkg::IDX_STAT;
        s.data = a[7:2] == uart_ctl_pkg::IDX_DATA;
        return s;
    endfunction

    tx_link_if lnk ();

    logic [7:0] lineCtl_ff, txrx_ff, rxData_ff, txBuf_ff;
    logic [5:0] ninthEn_ff;
    logic tx9_ff, rx9_ff;
    logic txEmpty_ff, full_ff, idle_ff, ovr_ff, noise_ff, frame_ff, par_ff;
    logic awGot_ff, wGot_ff, bvalid_ff, rvalid_ff;
    logic [7:0] wAddr_ff, wData_ff, rdata_ff;
    logic wStrb0_ff;
    logic [1:0] bresp_ff, rresp_ff;
    rxState_e rxState_ff;
    logic [uart_ctl_pkg::BAUD_W-1:0] rxCnt_ff;
    logic [3:0] rxBit_ff, idleCnt_ff;
    logic [9:0] rxSh_ff;
    logic [2:0] smp_ff;
    logic frNoise_ff, idleArm_ff;

    // Control field decode
    wire loopOn = lineCtl_ff[uart_ctl_pkg::LF_LOOP];
    wire modOn = lineCtl_ff[uart_ctl_pkg::LF_ENA];
    wire nine = lineCtl_ff[uart_ctl_pkg::LF_NINE];
    wire wakeAddr = lineCtl_ff[uart_ctl_pkg::LF_WAKE];
    wire idleAfterStop = lineCtl_ff[uart_ctl_pkg::LF_IDLEPOS];
    wire parOn = lineCtl_ff[uart_ctl_pkg::LF_PAREN];
    wire parOdd = lineCtl_ff[uart_ctl_pkg::LF_PARODD];
    wire txOn = txrx_ff[uart_ctl_pkg::TR_TXEN];
    wire rxOn = modOn & txrx_ff[uart_ctl_pkg::TR_RXEN];
    wire stby = txrx_ff[uart_ctl_pkg::TR_STBY];
    wire [3:0] frameLen = nine ? uart_ctl_pkg::FRAME9 : uart_ctl_pkg::FRAME8;

    // Bus slave: address and data taken in either order, answer after both
    wire doWrite = awGot_ff & wGot_ff & !bvalid_ff;
    uart_ctl_pkg::regSel_s wSel;
    uart_ctl_pkg::regSel_s rSel;
    assign wSel = decodeIdx(wAddr_ff);
    assign rSel = decodeIdx(araddr);
    wire wLane = doWrite & wStrb0_ff;
    wire wrLine = wLane & wSel.line;
    wire wrTxrx = wLane & wSel.txrx;
    wire wrNinth = wLane & wSel.ninth;
    wire wrData = wLane & wSel.data;
    wire arTake = arvalid & !rvalid_ff;
    wire dataRead = arTake & rSel.data;
    assign awready = !awGot_ff & !bvalid_ff;
    assign wready = !wGot_ff & !bvalid_ff;
    assign arready = !rvalid_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rresp = rresp_ff;
    assign rdata = {24'h000000, rdata_ff};

    // Transmit side
    wire txDone = txEmpty_ff & !lnk.active;
    assign lnk.modEnable = modOn;
    assign lnk.txEnable = modOn & txOn;
    assign lnk.sendBreak = txrx_ff[uart_ctl_pkg::TR_BRK];
    assign lnk.nineBit = nine;
    assign lnk.parityEn = parOn;
    assign lnk.parityOdd = parOdd;
    assign lnk.loadValid = modOn & !txEmpty_ff;
    assign lnk.loadData = txBuf_ff;
    assign lnk.loadNinth = tx9_ff;
    assign txd = lnk.txd;
    // With the module enabled, pin released only once a character in flight has gone out
    assign txdOe = modOn & (txOn | lnk.active);

    uart_tx_engine txEngine (
        .clk(clk),
        .nrst(nrst),
        .lnk(lnk)
    );

    // Receive side
    wire rxIn = loopOn ? lnk.txd : rxd;
    wire tickR = rxCnt_ff == uart_ctl_pkg::BIT_LAST;
    wire sampWin = rxCnt_ff >= uart_ctl_pkg::SAMP_LO && rxCnt_ff <= uart_ctl_pkg::SAMP_HI;
    // Three mid-bit samples: majority decides, disagreement marks noise
    wire bitVal = (smp_ff[0] & smp_ff[1]) | (smp_ff[1] & smp_ff[2]) | (smp_ff[0] & smp_ff[2]);
    wire noisy = |smp_ff & !(&smp_ff);
    wire inFrame = rxState_ff == RX_BITS;
    wire [3:0] stopIdx = nine ? uart_ctl_pkg::STOP9 : uart_ctl_pkg::STOP8;
    wire falseStart = inFrame & tickR & rxBit_ff == 4'h0 & bitVal;
    wire charDone = inFrame & tickR & rxBit_ff == stopIdx;
    wire [9:0] newSh = {bitVal, rxSh_ff[9:1]};
    wire [7:0] chData = nine ? newSh[7:0] : newSh[8:1];
    wire chMsb = newSh[8];
    wire chPar = nine ? ^newSh[8:0] : ^newSh[8:1];
    wire wakeMark = charDone & stby & wakeAddr & chMsb;
    wire accept = charDone & (!stby | wakeMark);
    wire loadChar = accept & !full_ff;
    wire startSeen = rxOn & !inFrame & !rxIn;
    // After-stop counting only runs between characters
    wire countOn = !inFrame | (!idleAfterStop & rxBit_ff != 4'h0);
    wire idleHit = tickR & countOn & bitVal & idleCnt_ff == frameLen - 4'h1;
    wire idleWake = idleHit & stby & !wakeAddr;
    wire idleSet = idleHit & idleArm_ff & !stby;
    wire hwWake = wakeMark | idleWake;

    // Register write and read values
    wire [7:0] wTxrx = {wData_ff[7:4],
        modOn ? wData_ff[3:2] : txrx_ff[3:2], wData_ff[1:0]};
    wire [7:0] nxt_txrx = (wrTxrx ? wTxrx : txrx_ff) &
        ~(8'(hwWake) << uart_ctl_pkg::TR_STBY);
    wire [7:0] statByte = {txEmpty_ff, txDone, full_ff, idle_ff,
        ovr_ff, noise_ff, frame_ff, par_ff};
    wire [7:0] rdMux = rSel.line ? lineCtl_ff : rSel.txrx ? txrx_ff :
        rSel.ninth ? {rx9_ff, tx9_ff, ninthEn_ff} : rSel.stat ? statByte :
        rSel.data ? rxData_ff : 8'h00;

    // Interrupt requests
    assign txIrq = modOn & ((txrx_ff[uart_ctl_pkg::TR_EMPIE] & txEmpty_ff) |
        (txrx_ff[uart_ctl_pkg::TR_DONEIE] & txDone));
    assign rxIrq = !stby & ((txrx_ff[uart_ctl_pkg::TR_FULLIE] & full_ff) |
        (txrx_ff[uart_ctl_pkg::TR_IDLEIE] & idle_ff));
    assign errIrq = (ninthEn_ff[uart_ctl_pkg::NB_OVIE] & ovr_ff) |
        (ninthEn_ff[uart_ctl_pkg::NB_NOIE] & noise_ff) |
        (ninthEn_ff[uart_ctl_pkg::NB_FRIE] & frame_ff) |
        (ninthEn_ff[uart_ctl_pkg::NB_PARIE] & par_ff);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awGot_ff <= 1'b0;
            wGot_ff <= 1'b0;
            wAddr_ff <= 8'h00;
            wData_ff <= 8'h00;
            wStrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= uart_ctl_pkg::RESP_OKAY;
        end else begin
            if (awvalid & awready) begin
                awGot_ff <= 1'b1;
                wAddr_ff <= awaddr;
            end else if (doWrite) begin
                awGot_ff <= 1'b0;
            end
            if (wvalid & wready) begin
                wGot_ff <= 1'b1;
                wData_ff <= wdata[7:0];
                wStrb0_ff <= wstrb[0];
            end else if (doWrite) begin
                wGot_ff <= 1'b0;
            end
            if (doWrite) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= |wSel ? uart_ctl_pkg::RESP_OKAY : uart_ctl_pkg::RESP_SLVERR;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rresp_ff <= uart_ctl_pkg::RESP_OKAY;
        end else if (arTake) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rdMux;
            rresp_ff <= |rSel ? uart_ctl_pkg::RESP_OKAY : uart_ctl_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lineCtl_ff <= uart_ctl_pkg::LINE_RST;
            txrx_ff <= uart_ctl_pkg::TXRX_RST;
            ninthEn_ff <= uart_ctl_pkg::NINTH_RST;
        end else begin
            if (wrLine) begin
                lineCtl_ff <= {wData_ff[7:6], 1'b0, wData_ff[4:0]};
            end
            txrx_ff <= nxt_txrx;
            if (wrNinth) begin
                ninthEn_ff <= wData_ff[5:0];
            end
        end
    end

    // Data and ninth bits keep their contents through reset
    always_ff @(posedge clk) begin
        if (wrNinth) begin
            tx9_ff <= wData_ff[6];
        end
        if (wrData) begin
            txBuf_ff <= wData_ff;
        end
        if (loadChar) begin
            rxData_ff <= chData;
            rx9_ff <= chMsb;
        end
    end

    // Status flags: a hardware set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txEmpty_ff <= 1'b1;
            full_ff <= 1'b0;
            idle_ff <= 1'b0;
            ovr_ff <= 1'b0;
            noise_ff <= 1'b0;
            frame_ff <= 1'b0;
            par_ff <= 1'b0;
            idleArm_ff <= 1'b0;
        end else begin
            txEmpty_ff <= lnk.loadTaken | !modOn | (txEmpty_ff & !wrData);
            full_ff <= loadChar | (full_ff & !dataRead);
            idle_ff <= idleSet | (idle_ff & !dataRead);
            ovr_ff <= (accept & full_ff) | (ovr_ff & !dataRead);
            noise_ff <= (loadChar & (frNoise_ff | noisy)) | (noise_ff & !dataRead);
            frame_ff <= (loadChar & !newSh[9]) | (frame_ff & !dataRead);
            par_ff <= (loadChar & parOn & (chPar != parOdd)) | (par_ff & !dataRead);
            idleArm_ff <= rxOn & (loadChar | (idleArm_ff & !idleSet));
        end
    end

    // Receiver timing and shifting
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxState_ff <= RX_IDLE;
            rxCnt_ff <= '0;
            rxBit_ff <= 4'h0;
            rxSh_ff <= 10'h000;
            smp_ff <= 3'h7;
            frNoise_ff <= 1'b0;
        end else if (!rxOn) begin
            rxState_ff <= RX_IDLE;
            rxCnt_ff <= '0;
            rxBit_ff <= 4'h0;
            frNoise_ff <= 1'b0;
        end else begin
            rxCnt_ff <= (startSeen | tickR) ? '0 : rxCnt_ff + 1'b1;
            if (sampWin) begin
                smp_ff <= {rxIn, smp_ff[2:1]};
            end
            unique case (rxState_ff)
                RX_IDLE: begin
                    if (startSeen) begin
                        rxState_ff <= RX_BITS;
                        rxBit_ff <= 4'h0;
                        frNoise_ff <= 1'b0;
                    end
                end
                RX_BITS: begin
                    if (falseStart | charDone) begin
                        rxState_ff <= RX_IDLE;
                    end else if (tickR) begin
                        rxBit_ff <= rxBit_ff + 4'h1;
                        rxSh_ff <= newSh;
                        frNoise_ff <= frNoise_ff | noisy;
                    end
                end
            endcase
        end
    end

    // Idle character counter, saturating at the character length
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idleCnt_ff <= 4'h0;
        end else if (!rxOn) begin
            idleCnt_ff <= 4'h0;
        end else if (tickR) begin
            if (!(countOn & bitVal)) begin
                idleCnt_ff <= 4'h0;
            end else if (idleCnt_ff < frameLen) begin
                idleCnt_ff <= idleCnt_ff + 4'h1;
            end
        end
    end

    addr_wake_a: assert property (@(posedge clk) disable iff (!nrst)
        wakeMark & !full_ff |=> !stby && full_ff && rx9_ff)
        else $error("address mark did not wake the receiver");
    idle_wake_a: assert property (@(posedge clk) disable iff (!nrst)
        idleWake |=> !stby && (!idle_ff || $past(idle_ff)))
        else $error("idle line did not end standby cleanly");
    loop_path_a: assert property (@(posedge clk) disable iff (!nrst)
        loopOn & rxOn & !inFrame & !lnk.txd |=> rxState_ff == RX_BITS)
        else $error("loopback did not reach the receiver");
    disable_flags_a: assert property (@(posedge clk) disable iff (!nrst)
        !modOn |=> txEmpty_ff && !txIrq || modOn)
        else $error("module disable left the transmit flags clear");
    enable_lock_a: assert property (@(posedge clk) disable iff (!nrst)
        wrTxrx & !modOn |=> txrx_ff[3:2] == $past(txrx_ff[3:2]))
        else $error("enables changed while module disabled");
    standby_mask_a: assert property (@(posedge clk) disable iff (!nrst)
        stby |-> !rxIrq)
        else $error("receiver request raised in standby");
    err_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        frame_ff & ninthEn_ff[uart_ctl_pkg::NB_FRIE] |-> errIrq)
        else $error("framing error request missing");
    write_answer_a: assert property (@(posedge clk) disable iff (!nrst)
        awvalid & awready & wvalid & wready |=> ##1 bvalid)
        else $error("write answer late");
    char_rx_c: cover property (@(posedge clk) disable iff (!nrst) loadChar);
    idle_set_c: cover property (@(posedge clk) disable iff (!nrst) idleSet);
endmodule

// File: bench/remote_uart.sv
// Remote transceiver model on the far side of the serial line
module remote_uart (
    input wire logic clk,
    output logic lineOut,
    input wire logic lineIn
);
    timeunit 1ns;
    timeprecision 1ps;
    int lowCount;
    initial lineOut = 1'b1;
    // Length of the current low run on the transmit line
    always @(posedge clk) lowCount <= lineIn ? 0 : lowCount + 1;
    task automatic send(input logic [7:0] val, input logic stopBit);
        logic [9:0] frame;
        frame = {stopBit, val, 1'b0};
        for (int i = 0; i < 10; i++) begin
            lineOut <= frame[i];
            repeat (uart_ctl_pkg::BIT_CYCLES) @(posedge clk);
        end
        // Line returns to idle even after a forced low stop bit
        lineOut <= 1'b1;
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the serial control register block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, rxd, txd, txdOe, txIrq, rxIrq;
    logic awready, wready, bvalid, arready, rvalid, errIrq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int miscompares, checks, n;
    uart_control_registers uart_control_registers_inst (.*);
    remote_uart remote_uart_inst (.clk(clk), .lineOut(rxd), .lineIn(txd));
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Every wait is bounded; a hang closes the run
    task automatic hang();
        if (n >= 400) begin
            miscompares++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 400);
        rsp = bresp;
        bready <= 1'b0;
        hang();
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 400);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        hang();
    endtask
    task automatic t_reset();
        rdr(8'h50);
        check(rd, 32'h0);
        rdr(8'h4c);
        check(rd, 32'h0);
        rdr(8'h54);
        check(rd[5:0], 32'h0);
        rdr(8'h58);
        check(rd, 32'hc0);
        check(txdOe, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_regs();
        wr(8'h4c, 8'h7f);
        rdr(8'h4c);
        check(rd, 32'h5f);
        wr(8'h54, 8'h0f);
        rdr(8'h54);
        check(rd[5:0], 32'h0f);
        check(errIrq, 32'h0);
        wr(8'h7c, 8'h11);
        check(rsp, 32'h2);
        rdr(8'h7c);
        check(rsp, 32'h2);
        check(rd, 32'h0);
        wr(8'h4c, 8'h40);
        $display("register test done");
    endtask
    task automatic t_tx();
        wr(8'h50, 8'h88);
        check(txIrq, 32'h1);
        check(txdOe, 32'h1);
        wr(8'h60, 8'h55);
        // Preamble of ten ones must precede the start bit
        for (n = 0; n < 400 && txd !== 1'b0; n++) @(posedge clk);
        check(n >= 140 && n <= 200, 32'h1);
        wr(8'h50, 8'h08);
        check(txIrq, 32'h0);
        repeat (400) @(posedge clk);
        rdr(8'h58);
        check(rd[7:6], 32'h3);
        $display("transmit test done");
    endtask
    task automatic t_break();
        wr(8'h50, 8'h09);
        repeat (400) @(posedge clk);
        check(remote_uart_inst.lowCount >= 300, 32'h1);
        wr(8'h50, 8'h08);
        repeat (400) @(posedge clk);
        check(txd, 32'h1);
        $display("break test done");
    endtask
    task automatic t_rx();
        wr(8'h50, 8'h24);
        remote_uart_inst.send(8'ha5, 1'b1);
        repeat (20) @(posedge clk);
        check(rxIrq, 32'h1);
        wr(8'h50, 8'h26);
        check(rxIrq, 32'h0);
        rdr(8'h54);
        check(rd[7], 32'h1);
        rdr(8'h60);
        check(rd, 32'ha5);
        wr(8'h4c, 8'h48);
        remote_uart_inst.send(8'h81, 1'b1);
        repeat (20) @(posedge clk);
        rdr(8'h50);
        check(rd, 32'h24);
        rdr(8'h58);
        check(rd[5], 32'h1);
        $display("receive test done");
    endtask
    task automatic t_loop();
        rdr(8'h60);
        check(rd, 32'h81);
        wr(8'h4c, 8'hc0);
        wr(8'h50, 8'h0c);
        // Pin traffic must not reach the receiver in loop mode
        remote_uart_inst.send(8'h00, 1'b1);
        rdr(8'h58);
        check(rd[5], 32'h0);
        wr(8'h60, 8'h3c);
        repeat (400) @(posedge clk);
        rdr(8'h60);
        check(rd, 32'h3c);
        $display("loopback test done");
    endtask
    task automatic t_err();
        wr(8'h4c, 8'h42);
        // Even parity with a wrong parity bit and a low stop bit
        remote_uart_inst.send(8'h01, 1'b0);
        repeat (20) @(posedge clk);
        check(errIrq, 32'h1);
        rdr(8'h58);
        check(rd[1:0], 32'h3);
        rdr(8'h60);
        check(rd, 32'h01);
        check(errIrq, 32'h0);
        $display("error test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_regs();
        t_tx();
        t_break();
        t_rx();
        t_loop();
        t_err();
        complete_run();
    end
endmodule
